// ===== nand_page_ecc_decoder.sv
// Page codec sequencer: detect, correct and report sector by sector
`timescale 1ns/1ps
`default_nettype none
`include "ecc_dec_cfg.svh"
module nand_page_ecc_decoder
    import ecc_dec_pkg::*;
#(
    parameter int SECTORS      = `ECC_SECTORS,
    parameter int SECTOR_BYTES = `ECC_SECTOR_BYTES,
    parameter int MAX_ERR      = `ECC_MAX_ERR,
    localparam int BW          = $clog2(SECTOR_BYTES),
    localparam int SW          = (SECTORS > 1) ? $clog2(SECTORS) : 1,
    localparam int PW          = BW + 3,
    localparam int EW          = $clog2(MAX_ERR + 1),
    localparam int IW          = (MAX_ERR > 1) ? $clog2(MAX_ERR) : 1
) (
    input  wire logic                   REF_CLK,
    input  wire logic                   RST,
    input  wire logic                   START,
    input  wire logic                   CODEC_DIR,
    input  wire logic                   CODE_STRENGTH,
    input  wire logic                   CORR_SELECT,
    output logic                        DET_RD_EN,
    output logic [SW+BW-1:0]            DET_RD_ADDR,
    input  wire logic [7:0]             DET_RD_DATA,
    input  wire logic [7:0]             DET_RD_CHECK,
    output logic                        OUT_WR_EN,
    output logic [SW+BW-1:0]            OUT_WR_ADDR,
    output logic [7:0]                  OUT_WR_DATA,
    output logic [7:0]                  OUT_WR_CHECK,
    input  wire logic [SW-1:0]          POS_SECTOR,
    input  wire logic [IW-1:0]          POS_INDEX,
    output logic [PW-1:0]               POS_DATA,
    output logic [EW-1:0]               POS_COUNT,
    output logic [2*SECTORS-1:0]        DECODE_STATE,
    output logic [SECTORS-1:0]          ERR_STATUS,
    output logic                        UNCORR_IRQ,
    output logic                        BUSY,
    output logic                        PAGE_DONE
);

    byte_check_if chk ();

    ecc_state_t          state_q;
    logic [SW-1:0]       sector_q;
    logic [BW-1:0]       byte_q;
    logic                dir_q;
    logic                strength_q;
    logic                corr_q;
    logic [EW-1:0]       nerr_q [SECTORS];
    logic [PW-1:0]       pos_q [SECTORS][MAX_ERR];
    sector_state_t       dstate_q [SECTORS];
    logic [SECTORS-1:0]  status_q;
    logic                wr_en_q;
    logic [SW+BW-1:0]    wr_addr_q;
    logic [7:0]          wr_data_q;
    logic [7:0]          wr_check_q;
    logic                irq_q;
    logic                done_q;
    logic [PW-1:0]       pos_data_q;
    logic [EW-1:0]       pos_count_q;
    logic                last_byte;
    logic                last_sector;
    logic                needs_fix;

    byte_checker u_checker (
        .clk (REF_CLK),
        .rst (RST),
        .chk (chk)
    );

    assign last_byte   = (byte_q == BW'(SECTOR_BYTES - 1));
    assign last_sector = (sector_q == SW'(SECTORS - 1));
    // Correction needs errors, a correctable count and the automatic mode
    assign needs_fix   = (chk.count != 4'h0) && !chk.uncorrectable
                         && (corr_q == `ECC_CORR_AUTO);

    assign chk.data     = DET_RD_DATA;
    assign chk.check    = DET_RD_CHECK;
    assign chk.strength = strength_q;
    assign chk.valid    = (state_q == S_DET_EV) && (dir_q == `ECC_DIR_DECODE);
    assign chk.clear    = (state_q == S_IDLE) || (state_q == S_REPORT);

    // Buffer fetch for both passes over the sector
    assign DET_RD_EN   = (state_q == S_DET_RD) || (state_q == S_COR_RD);
    assign DET_RD_ADDR = {sector_q, byte_q};

    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            state_q    <= S_IDLE;
            sector_q   <= '0;
            byte_q     <= '0;
            dir_q      <= `ECC_DIR_ENCODE;
            strength_q <= `ECC_STRENGTH_BCH4;
            corr_q     <= `ECC_CORR_SOFTWARE;
        end else begin
            unique case (state_q)
                S_IDLE: begin
                    if (START) begin
                        dir_q      <= CODEC_DIR;
                        strength_q <= CODE_STRENGTH;
                        corr_q     <= CORR_SELECT;
                        sector_q   <= '0;
                        byte_q     <= '0;
                        state_q    <= S_DET_RD;
                    end
                end
                S_DET_RD: state_q <= S_DET_EV;
                S_DET_EV: begin
                    if (!last_byte) begin
                        byte_q  <= byte_q + BW'(1);
                        state_q <= S_DET_RD;
                    end else if (dir_q == `ECC_DIR_ENCODE) begin
                        byte_q  <= '0;
                        if (last_sector) begin
                            state_q <= S_DONE;
                        end else begin
                            sector_q <= sector_q + SW'(1);
                            state_q  <= S_DET_RD;
                        end
                    end else begin
                        byte_q  <= '0;
                        state_q <= needs_fix ? S_COR_RD : S_REPORT;
                    end
                end
                S_COR_RD: state_q <= S_COR_EV;
                S_COR_EV: begin
                    if (last_byte) begin
                        byte_q  <= '0;
                        state_q <= S_REPORT;
                    end else begin
                        byte_q  <= byte_q + BW'(1);
                        state_q <= S_COR_RD;
                    end
                end
                S_REPORT: begin
                    if (last_sector) begin
                        state_q <= S_DONE;
                    end else begin
                        sector_q <= sector_q + SW'(1);
                        state_q  <= S_DET_RD;
                    end
                end
                S_DONE: state_q <= S_IDLE;
                default: state_q <= S_IDLE;
            endcase
        end
    end

    // Error positions caught during detection, bit address within sector
    always_ff @(posedge REF_CLK or posedge RST) begin
        int n;
        if (RST) begin
            for (int s = 0; s < SECTORS; s++) begin
                nerr_q[s] <= '0;
                for (int e = 0; e < MAX_ERR; e++) begin
                    pos_q[s][e] <= '0;
                end
            end
        end else if (state_q == S_DET_RD && byte_q == '0 && dir_q == `ECC_DIR_DECODE) begin
            nerr_q[sector_q] <= '0;
        end else if (chk.valid) begin
            n = int'(nerr_q[sector_q]);
            for (int b = 0; b < 8; b++) begin
                if (chk.mask[b] && n < MAX_ERR) begin
                    pos_q[sector_q][n] <= {byte_q, 3'(b)};
                    n = n + 1;
                end
            end
            nerr_q[sector_q] <= EW'(n);
        end
    end

    // Per-sector outcome, interrupt pulse
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            for (int s = 0; s < SECTORS; s++) begin
                dstate_q[s] <= `ECC_DS_CLEAN;
            end
            status_q <= '0;
            irq_q    <= 1'b0;
        end else begin
            irq_q <= 1'b0;
            if (state_q == S_IDLE && START && CODEC_DIR == `ECC_DIR_DECODE) begin
                status_q <= '0;
            end else if (state_q == S_REPORT) begin
                if (chk.uncorrectable) begin
                    dstate_q[sector_q] <= `ECC_DS_UNCORR;
                    irq_q              <= 1'b1;
                end else if (chk.count != 4'h0) begin
                    dstate_q[sector_q] <= `ECC_DS_CORRECTABLE;
                end else begin
                    dstate_q[sector_q] <= `ECC_DS_CLEAN;
                end
                status_q[sector_q] <= (chk.count != 4'h0);
            end
        end
    end

    // Output buffer writes: encoded data, or corrected data in auto mode
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            wr_en_q    <= 1'b0;
            wr_addr_q  <= '0;
            wr_data_q  <= 8'h00;
            wr_check_q <= 8'h00;
        end else begin
            wr_en_q <= 1'b0;
            if (state_q == S_COR_EV) begin
                wr_en_q    <= 1'b1;
                wr_addr_q  <= {sector_q, byte_q};
                wr_data_q  <= DET_RD_DATA ^ chk.mask;
                wr_check_q <= DET_RD_CHECK;
            end else if (state_q == S_DET_EV && dir_q == `ECC_DIR_ENCODE) begin
                wr_en_q    <= 1'b1;
                wr_addr_q  <= {sector_q, byte_q};
                wr_data_q  <= DET_RD_DATA;
                wr_check_q <= DET_RD_DATA;
            end
        end
    end

    // Software readback of positions, page done pulse
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            pos_data_q  <= '0;
            pos_count_q <= '0;
            done_q      <= 1'b0;
        end else begin
            pos_data_q  <= pos_q[POS_SECTOR][POS_INDEX];
            pos_count_q <= nerr_q[POS_SECTOR];
            done_q      <= (state_q == S_DONE);
        end
    end

    // Software mode never reaches the correction states
    assign OUT_WR_EN    = wr_en_q;
    assign OUT_WR_ADDR  = wr_addr_q;
    assign OUT_WR_DATA  = wr_data_q;
    assign OUT_WR_CHECK = wr_check_q;
    assign POS_DATA     = pos_data_q;
    assign POS_COUNT    = pos_count_q;
    assign ERR_STATUS   = status_q;
    assign UNCORR_IRQ   = irq_q;
    assign PAGE_DONE    = done_q;
    assign BUSY         = (state_q != S_IDLE);

    generate
        for (genvar g = 0; g < SECTORS; g++) begin : g_ds
            assign DECODE_STATE[2*g +: 2] = dstate_q[g];
        end
    endgenerate

endmodule
`default_nettype wire

// ===== ecc_dec_cfg.svh
// Constants of the page decoder: sizes, codes and limits
`ifndef ECC_DEC_CFG_SVH
`define ECC_DEC_CFG_SVH

`define ECC_SECTOR_BYTES   512
`define ECC_SECTORS        4
`define ECC_MAX_ERR        8
`define ECC_LIMIT_BCH4     4'h4
`define ECC_LIMIT_BCH8     4'h8
`define ECC_COUNT_SAT      4'hF
`define ECC_DIR_ENCODE     1'b0
`define ECC_DIR_DECODE     1'b1
`define ECC_CORR_SOFTWARE  1'b0
`define ECC_CORR_AUTO      1'b1
`define ECC_STRENGTH_BCH4  1'b0
`define ECC_STRENGTH_BCH8  1'b1
`define ECC_DS_CLEAN       2'h0
`define ECC_DS_CORRECTABLE 2'h1
`define ECC_DS_UNCORR      2'h2

`endif

// ===== ecc_dec_pkg.sv
// Types shared by the page decoder modules
package ecc_dec_pkg;

    typedef enum logic [2:0] {
        S_IDLE   = 3'b000,
        S_DET_RD = 3'b001,
        S_DET_EV = 3'b010,
        S_COR_RD = 3'b011,
        S_COR_EV = 3'b100,
        S_REPORT = 3'b101,
        S_DONE   = 3'b110
    } ecc_state_t;

    typedef logic [1:0] sector_state_t;

endpackage

// ===== byte_check_if.sv
// Carrier between the sequencer and the byte checker
`timescale 1ns/1ps
`default_nettype none
interface byte_check_if;
    logic [7:0] data;
    logic [7:0] check;
    logic       strength;
    logic       clear;
    logic       valid;
    logic [7:0] mask;
    logic [3:0] count;
    logic       uncorrectable;

    modport seq  (output data, check, strength, clear, valid,
                  input  mask, count, uncorrectable);
    modport unit (input  data, check, strength, clear, valid,
                  output mask, count, uncorrectable);
endinterface
`default_nettype wire

// ===== byte_checker.sv
// Per-byte error detector with sector error counter
`timescale 1ns/1ps
`default_nettype none
`include "ecc_dec_cfg.svh"
module byte_checker
    import ecc_dec_pkg::*;
(
    input  wire logic   clk,
    input  wire logic   rst,
    byte_check_if.unit  chk
);

    logic [3:0] count_q;
    logic [3:0] count_d;
    logic [3:0] limit;

    function automatic logic [3:0] popcount8(input logic [7:0] v);
        logic [3:0] s;
        s = 4'h0;
        for (int i = 0; i < 8; i++) begin
            s = s + {3'h0, v[i]};
        end
        return s;
    endfunction

    assign chk.mask  = chk.data ^ chk.check;
    // Count includes the byte under evaluation, so the last byte weighs in the fix decision
    assign chk.count = count_d;
    assign limit     = (chk.strength == `ECC_STRENGTH_BCH8) ? `ECC_LIMIT_BCH8
                                                             : `ECC_LIMIT_BCH4;
    assign chk.uncorrectable = (count_d > limit);

    // Saturating sum keeps a heavily damaged sector uncorrectable
    always_comb begin
        count_d = count_q;
        if (chk.valid) begin
            if ({1'b0, count_q} + {1'b0, popcount8(chk.mask)} > {1'b0, `ECC_COUNT_SAT}) begin
                count_d = `ECC_COUNT_SAT;
            end else begin
                count_d = count_q + popcount8(chk.mask);
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            count_q <= 4'h0;
        end else if (chk.clear) begin
            count_q <= 4'h0;
        end else begin
            count_q <= count_d;
        end
    end

endmodule
`default_nettype wire

// ===== ecc_dec_asserts.sv
// Port assertions for the page decoder
`timescale 1ns/1ps
`default_nettype none
module ecc_dec_asserts #(
    parameter int  SECTORS      = 4,
    parameter int  SECTOR_BYTES = 512,
    localparam int AW           = ((SECTORS > 1) ? $clog2(SECTORS) : 1) + $clog2(SECTOR_BYTES)
) (
    input wire logic               REF_CLK,
    input wire logic               RST,
    input wire logic               START,
    input wire logic               CODEC_DIR,
    input wire logic               CORR_SELECT,
    input wire logic               DET_RD_EN,
    input wire logic [AW-1:0]      DET_RD_ADDR,
    input wire logic               OUT_WR_EN,
    input wire logic [AW-1:0]      OUT_WR_ADDR,
    input wire logic [7:0]         OUT_WR_DATA,
    input wire logic [7:0]         OUT_WR_CHECK,
    input wire logic [SECTORS-1:0] ERR_STATUS,
    input wire logic               UNCORR_IRQ,
    input wire logic               BUSY,
    input wire logic               PAGE_DONE
);
    logic dir_q;
    logic corr_q;

    // Mode of the page in progress
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            dir_q  <= 1'b0;
            corr_q <= 1'b0;
        end else if (START && !BUSY) begin
            dir_q  <= CODEC_DIR;
            corr_q <= CORR_SELECT;
        end
    end

    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (RST);

    sequence s_taken;
        START && !BUSY;
    endsequence
    sequence s_first_read;
        DET_RD_EN && (DET_RD_ADDR == '0);
    endsequence

    a_start_fetch: assert property (s_taken |=> s_first_read)
        else $error("first buffer read missing after start");
    a_sw_quiet: assert property (BUSY && dir_q && !corr_q |-> !OUT_WR_EN)
        else $error("output write in software correction");
    a_enc_copy: assert property (OUT_WR_EN && !dir_q |-> OUT_WR_DATA == OUT_WR_CHECK)
        else $error("encode output pair differs");
    a_wr_source: assert property (OUT_WR_EN |-> $past(DET_RD_EN, 2) && OUT_WR_ADDR == $past(DET_RD_ADDR, 2))
        else $error("output write without matching reread");
    a_rd_spacing: assert property (DET_RD_EN |=> !DET_RD_EN)
        else $error("buffer reads back to back");
    a_irq_pulse: assert property (UNCORR_IRQ |-> BUSY ##1 !UNCORR_IRQ)
        else $error("interrupt pulse malformed");
    a_done_end: assert property ($fell(BUSY) |-> PAGE_DONE ##1 !PAGE_DONE)
        else $error("page done pulse missing at end");
    a_status_clear: assert property (s_taken ##0 CODEC_DIR |=> ERR_STATUS == '0)
        else $error("error status not cleared on decode start");
endmodule
`default_nettype wire

// ===== det_buffer_model.sv
// Detect input buffer and correction output buffer model
`timescale 1ns/1ps
`default_nettype none
module det_buffer_model #(
    parameter int AW = 4
) (
    input  wire logic          clk,
    input  wire logic          rd_en,
    input  wire logic [AW-1:0] rd_addr,
    output logic [7:0]         rd_data,
    output logic [7:0]         rd_check,
    input  wire logic          wr_en,
    input  wire logic [AW-1:0] wr_addr,
    input  wire logic [7:0]    wr_data
);
    logic [7:0] data_mem  [2**AW];
    logic [7:0] check_mem [2**AW];
    logic [7:0] out_mem   [2**AW];

    initial begin
        rd_data  = 8'h00;
        rd_check = 8'h00;
    end
    // One-cycle read latency; stale data inverted otherwise
    always @(posedge clk) begin
        if (rd_en) begin
            rd_data  <= data_mem[rd_addr];
            rd_check <= check_mem[rd_addr];
        end else begin
            rd_data  <= ~rd_data;
            rd_check <= ~rd_check;
        end
        if (wr_en) out_mem[wr_addr] <= wr_data;
    end
endmodule
`default_nettype wire

// ===== tb_top.sv
// Self-checking bench for the page decoder
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import ecc_dec_pkg::*;
    localparam int SECTORS      = 2;
    localparam int SECTOR_BYTES = 8;
    typedef struct packed {
        logic dir; logic str; logic corr;
        logic [4:0] n0; logic [4:0] n1; logic [3:0] state; logic [4:0] wr;
    } row_t;
    logic       clk, rst, start, dir, str, corr, rd_en, wr_en, irq, busy, done, pos_sector;
    logic [3:0] rd_addr, wr_addr, dstate, pos_count;
    logic [7:0] rd_data, rd_check, wr_data, wr_check;
    logic [2:0] pos_index;
    logic [5:0] pos_data;
    logic [1:0] estat;
    int         mismatches, checks, irqs, wrs;
    row_t       rows [7];

    nand_page_ecc_decoder #(.SECTORS(SECTORS), .SECTOR_BYTES(SECTOR_BYTES)) DUT (
        .REF_CLK(clk), .RST(rst), .START(start), .CODEC_DIR(dir), .CODE_STRENGTH(str),
        .CORR_SELECT(corr), .DET_RD_EN(rd_en), .DET_RD_ADDR(rd_addr), .DET_RD_DATA(rd_data),
        .DET_RD_CHECK(rd_check), .OUT_WR_EN(wr_en), .OUT_WR_ADDR(wr_addr),
        .OUT_WR_DATA(wr_data), .OUT_WR_CHECK(wr_check), .POS_SECTOR(pos_sector),
        .POS_INDEX(pos_index), .POS_DATA(pos_data), .POS_COUNT(pos_count),
        .DECODE_STATE(dstate), .ERR_STATUS(estat), .UNCORR_IRQ(irq), .BUSY(busy),
        .PAGE_DONE(done));
    det_buffer_model #(.AW(4)) u_ram (.clk(clk), .rd_en(rd_en), .rd_addr(rd_addr),
        .rd_data(rd_data), .rd_check(rd_check), .wr_en(wr_en), .wr_addr(wr_addr),
        .wr_data(wr_data));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk) begin
        if (irq === 1'b1) irqs++;
        if (wr_en === 1'b1) wrs++;
    end

    task chk(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task tick;
        @(posedge clk);
        #1;
    endtask
    task stop_test;
        $display("mismatches=%0d checks=%0d", mismatches, checks);
        if (mismatches == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // Fill buffer, flip data bits, run one page, compare results
    task run_page(input row_t r, input int poke);
        int a;
        int i;
        int n;
        logic fix;
        logic [7:0] exp_b;
        for (a = 0; a < 16; a++) begin
            u_ram.data_mem[a] = 8'(8'h3C + a);
            u_ram.check_mem[a] = 8'(8'h3C + a);
            u_ram.out_mem[a] = ~u_ram.check_mem[a];
        end
        // Damage the data bytes; the check bytes keep the good value
        for (a = 0; a < 2; a++) begin
            n = (a == 0) ? r.n0 : r.n1;
            for (i = 0; i < n; i++) u_ram.data_mem[a*8 + i%8][i/8] ^= 1'b1;
        end
        {dir, str, corr} = {r.dir, r.str, r.corr};
        start = 1'b1;
        tick;
        start = 1'b0;
        irqs = 0;
        wrs = 0;
        repeat (poke) tick;
        if (poke > 0) begin
            {start, dir} = {1'b1, ~r.dir};
            tick;
            start = 1'b0;
        end
        for (i = 0; i < 300 && done !== 1'b1; i++) tick;
        chk(done, 1'b1);
        chk(16'(wrs), r.wr);
        if (r.dir) begin
            chk(dstate, r.state);
            chk(estat, {r.n1 != 0, r.n0 != 0});
            chk(16'(irqs), 16'((r.state[1:0] == 2'h2) + (r.state[3:2] == 2'h2)));
            {pos_sector, pos_index} = {1'b0, 3'h1};
            tick;
            tick;
            chk(pos_count, r.n0);
            chk(pos_data, 6'h08);
        end
        for (a = 0; a < 16; a++) begin
            fix = !r.dir || (r.corr && r.state[2*(a/8) +: 2] == 2'h1);
            exp_b = fix ? u_ram.check_mem[a] : ~u_ram.check_mem[a];
            chk(u_ram.out_mem[a], exp_b);
        end
    endtask

    initial begin
        #(25 * 6000);
        mismatches++;
        stop_test;
    end

    initial begin
        rows[0] = '{1'b0, 1'b0, 1'b0, 5'h00, 5'h00, 4'h0, 5'h10};
        rows[1] = '{1'b1, 1'b0, 1'b1, 5'h03, 5'h00, 4'h1, 5'h08};
        rows[2] = '{1'b1, 1'b0, 1'b1, 5'h05, 5'h04, 4'h6, 5'h08};
        rows[3] = '{1'b1, 1'b1, 1'b1, 5'h08, 5'h09, 4'h9, 5'h08};
        rows[4] = '{1'b1, 1'b0, 1'b0, 5'h02, 5'h05, 4'h9, 5'h00};
        rows[5] = '{1'b1, 1'b1, 1'b0, 5'h00, 5'h0A, 4'h8, 5'h00};
        rows[6] = '{1'b0, 1'b1, 1'b1, 5'h00, 5'h00, 4'h0, 5'h10};
        {rst, start, dir, str, corr, pos_sector, pos_index} = '0;
        rst = 1'b1;
        repeat (20) @(posedge clk);
        #1;
        rst = 1'b0;
        chk({busy, done, rd_en, wr_en, irq, dstate, estat}, '0);
        for (int k = 0; k < 7; k++) run_page(rows[k], 0);
        // Start while busy is ignored
        run_page(rows[1], 5);
        // Reset in mid-page, then recover
        {dir, corr, start} = 3'b111;
        tick;
        start = 1'b0;
        repeat (10) tick;
        rst = 1'b1;
        tick;
        chk({busy, rd_en, wr_en, dstate, estat}, '0);
        rst = 1'b0;
        tick;
        run_page(rows[3], 0);
        stop_test;
    end
endmodule

bind nand_page_ecc_decoder ecc_dec_asserts #(.SECTORS(SECTORS), .SECTOR_BYTES(SECTOR_BYTES)) u_chk (
    .REF_CLK(REF_CLK), .RST(RST), .START(START), .CODEC_DIR(CODEC_DIR),
    .CORR_SELECT(CORR_SELECT), .DET_RD_EN(DET_RD_EN), .DET_RD_ADDR(DET_RD_ADDR),
    .OUT_WR_EN(OUT_WR_EN), .OUT_WR_ADDR(OUT_WR_ADDR), .OUT_WR_DATA(OUT_WR_DATA),
    .OUT_WR_CHECK(OUT_WR_CHECK), .ERR_STATUS(ERR_STATUS), .UNCORR_IRQ(UNCORR_IRQ),
    .BUSY(BUSY), .PAGE_DONE(PAGE_DONE));
`default_nettype wire
